// File: core/gain_load_pkg.sv
// Constants for the serial gain/current load port.
// Assumes a single system clock; all pins arrive asynchronous to it.
package gain_load_pkg;
	// ****************************************
	// Word layout
	// ****************************************
	localparam int word_bits = 10;
	localparam int fixed_one_pos = 0;
	localparam int reserved_pos = 1;
	localparam int gain_lsb = 2;
	localparam int gain_bits = 5;
	localparam int current_lsb = 7;
	localparam int current_bits = 3;
	localparam logic [2:0] current_off = 3'h0;
	localparam logic [2:0] current_max = 3'h7;
	// ****************************************
	// Reset values and synchroniser depth
	// ****************************************
	localparam logic [9:0] word_reset = 10'h001;
	localparam int sync_stages = 2;
	// Idle pin levels {tx_on, enable_n, clock, data}: only enable rests high
	localparam logic [3:0] pin_idle = 4'h4;
endpackage

// File: core/pin_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous pins.
// Assumes the destination clock is the system clock.
`timescale 1ns/1ps
module pin_sync #(
	parameter int width = 4,
	parameter logic [width-1:0] reset_value = '0
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Pins
	input wire logic [width-1:0] async_i,
	output logic [width-1:0] sync_o
);
	// ****************************************
	// Stages
	// ****************************************
	logic [width-1:0] first_reg;
	logic [width-1:0] first_next;
	logic [width-1:0] second_reg;
	logic [width-1:0] second_next;

	always_comb begin
		first_next = async_i;
		second_next = first_reg;
	end

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			first_reg <= reset_value;
			second_reg <= reset_value;
		end else begin
			first_reg <= first_next;
			second_reg <= second_next;
		end
	end

	assign sync_o = second_reg;
endmodule

// File: core/gain_current_serial_load.sv
// Serial load port of a programmable gain amplifier, with its active settings.
// Assumes serial clock, data, enable and transmit-on pins are asynchronous.
`timescale 1ns/1ps
module gain_current_serial_load
	import gain_load_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Serial load pins
	input wire logic ser_data_i,
	input wire logic ser_clk_i,
	input wire logic ser_enable_n_i,
	// Transmit control pin
	input wire logic tx_on_i,
	// Amplifier controls
	output logic amp_on_o,
	output logic input_stage_on_o,
	output logic [gain_load_pkg::gain_bits-1:0] gain_code_o,
	output logic [gain_load_pkg::current_bits-1:0] current_code_o,
	output logic [gain_load_pkg::word_bits-1:0] control_word_o
);
	import gain_load_pkg::*;

	// ****************************************
	// Pin synchronisation
	// ****************************************
	logic [3:0] pins_sync;
	logic data_s;
	logic clk_s;
	logic enable_n_s;
	logic tx_on_s;

	// Reset loads the idle pin levels, so no false edge follows reset
	pin_sync #(
		.width(4),
		.reset_value(pin_idle)
	) sync_u (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.async_i({tx_on_i, ser_enable_n_i, ser_clk_i, ser_data_i}),
		.sync_o(pins_sync)
	);

	assign data_s = pins_sync[0];
	assign clk_s = pins_sync[1];
	assign enable_n_s = pins_sync[2];
	assign tx_on_s = pins_sync[3];

	// ****************************************
	// Edge detection
	// ****************************************
	logic clk_prev_reg;
	logic clk_prev_next;
	logic enable_prev_reg;
	logic enable_prev_next;
	logic tx_prev_reg;
	logic tx_prev_next;
	logic clk_rise;
	logic enable_rise;
	logic tx_rise;

	// Serial clock phases shorter than one system clock may be missed
	always_comb begin
		clk_prev_next = clk_s;
		enable_prev_next = enable_n_s;
		tx_prev_next = tx_on_s;
		clk_rise = clk_s && !clk_prev_reg;
		enable_rise = enable_n_s && !enable_prev_reg;
		tx_rise = tx_on_s && !tx_prev_reg;
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			clk_prev_reg <= pin_idle[1];
			enable_prev_reg <= pin_idle[2];
			tx_prev_reg <= pin_idle[3];
		end else begin
			clk_prev_reg <= clk_prev_next;
			enable_prev_reg <= enable_prev_next;
			tx_prev_reg <= tx_prev_next;
		end
	end

	// ****************************************
	// Serial shift register
	// ****************************************
	logic shift_en;
	logic [word_bits-1:0] shift_in;
	logic [word_bits-1:0] shift_reg;
	logic [word_bits-1:0] shift_next;

	// Each bit takes its lower neighbour; bit zero takes the data line
	assign shift_in[0] = data_s;
	for (genvar b = 1; b < word_bits; b = b + 1) begin : g_shift
		assign shift_in[b] = shift_reg[b-1];
	end

	always_comb begin
		shift_en = clk_rise && !enable_n_s;
		shift_next = shift_reg;
		// Older bits fall off the top, so only the last ten edges count
		if (shift_en) begin
			shift_next = shift_in;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			shift_reg <= word_reset;
		end else begin
			shift_reg <= shift_next;
		end
	end

	// ****************************************
	// Control word latch
	// ****************************************
	logic [word_bits-1:0] word_reg;
	logic [word_bits-1:0] word_next;

	always_comb begin
		word_next = word_reg;
		// First bit sent ends up at bit nine, the last at bit zero
		if (enable_rise) begin
			word_next = shift_reg;
		end
	end

	// Held through transmit disable; only the serial port and reset change it
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			word_reg <= word_reset;
		end else begin
			word_reg <= word_next;
		end
	end

	// ****************************************
	// Field decode
	// ****************************************
	// Bits zero and one are stored and reach only control_word_o
	logic [gain_bits-1:0] word_gain;
	logic [current_bits-1:0] word_current;

	assign word_gain = word_reg[gain_lsb +: gain_bits];
	assign word_current = word_reg[current_lsb +: current_bits];

	// ****************************************
	// Active settings
	// ****************************************
	logic [gain_bits-1:0] gain_reg;
	logic [gain_bits-1:0] gain_next;
	logic [current_bits-1:0] current_reg;
	logic [current_bits-1:0] current_next;

	always_comb begin
		gain_next = gain_reg;
		current_next = current_reg;
		// Latched settings wait for a fresh turn-on, avoiding a glitch mid-burst
		if (tx_rise) begin
			gain_next = word_gain;
			current_next = word_current;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			gain_reg <= word_reset[gain_lsb +: gain_bits];
			current_reg <= word_reset[current_lsb +: current_bits];
		end else begin
			gain_reg <= gain_next;
			current_reg <= current_next;
		end
	end

	// ****************************************
	// Stage enables
	// ****************************************
	logic amp_on_reg;
	logic amp_on_next;
	logic input_on_reg;
	logic input_on_next;

	always_comb begin
		// Code zero shuts both stages, exactly as a low transmit-on does
		amp_on_next = tx_on_s && (current_next != current_off);
		input_on_next = amp_on_next;
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			amp_on_reg <= 1'b0;
			input_on_reg <= 1'b0;
		end else begin
			amp_on_reg <= amp_on_next;
			input_on_reg <= input_on_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign amp_on_o = amp_on_reg;
	assign input_stage_on_o = input_on_reg;
	assign gain_code_o = gain_reg;
	assign current_code_o = current_reg;
	assign control_word_o = word_reg;
endmodule

// File: tb/gain_load_asserts.sv
// Checker for the serial load port, bound to its top module.
// Assumes pin levels are held at least three clock cycles.
`timescale 1ns/1ps
module gain_load_asserts
	import gain_load_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ser_enable_n_i,
	input wire logic tx_on_i,
	input wire logic amp_on_o,
	input wire logic input_stage_on_o,
	input wire logic [gain_load_pkg::gain_bits-1:0] gain_code_o,
	input wire logic [gain_load_pkg::current_bits-1:0] current_code_o,
	input wire logic [gain_load_pkg::word_bits-1:0] control_word_o
);
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);
	// Synchroniser puts every update three to five edges behind its pin
	a_stage_mirror: assert property (amp_on_o == input_stage_on_o)
		else $error("stage enables differ");
	a_gain_field: assert property ($changed(gain_code_o) |-> gain_code_o == control_word_o[6:2])
		else $error("gain not from word");
	a_cur_field: assert property ($changed(current_code_o) |-> current_code_o == control_word_o[9:7])
		else $error("current not from word");
	a_amp_gated: assert property (amp_on_o |-> current_code_o != current_off)
		else $error("amp on with zero current");
	a_set_timing: assert property ($changed({gain_code_o, current_code_o}) |-> tx_on_i &&
		(!$past(tx_on_i, 3) || !$past(tx_on_i, 4) || !$past(tx_on_i, 5)))
		else $error("settings changed without tx cycle");
	a_word_timing: assert property ($changed(control_word_o) |-> ser_enable_n_i &&
		(!$past(ser_enable_n_i, 3) || !$past(ser_enable_n_i, 4) || !$past(ser_enable_n_i, 5)))
		else $error("word changed without enable rise");
	a_amp_rise: assert property ($rose(tx_on_i) && control_word_o[9:7] != 3'h0 |-> ##[1:5] amp_on_o)
		else $error("amp did not turn on");
	a_amp_fall: assert property ($fell(tx_on_i) |-> ##[1:5] !amp_on_o)
		else $error("amp did not turn off");
	a_tx_retain: assert property (!tx_on_i |-> $stable({gain_code_o, current_code_o}))
		else $error("settings lost while off");
	c_amp_on: cover property ($rose(amp_on_o));
	c_amp_off: cover property ($fell(amp_on_o));
	c_load_on: cover property ($changed(control_word_o) && tx_on_i);
endmodule
bind gain_current_serial_load gain_load_asserts u_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
	.ser_enable_n_i(ser_enable_n_i), .tx_on_i(tx_on_i), .amp_on_o(amp_on_o),
	.input_stage_on_o(input_stage_on_o), .gain_code_o(gain_code_o),
	.current_code_o(current_code_o), .control_word_o(control_word_o));

// File: tb/gain_host_model.sv
// Host side of the three-wire load bus, serial clock period eight cycles.
// Assumes the caller starts a transfer only with the bus idle.
`timescale 1ns/1ps
module gain_host_model (
	input wire logic clk_sys_i,
	output logic ser_data_o,
	output logic ser_clk_o,
	output logic ser_enable_n_o
);
	initial begin
		ser_data_o = 1'b0;
		ser_clk_o = 1'b0;
		ser_enable_n_o = 1'b1;
	end
	task automatic send(input logic [15:0] v, input int n);
		@(posedge clk_sys_i);
		ser_enable_n_o <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			ser_data_o <= v[i];
			repeat (4) @(posedge clk_sys_i);
			ser_clk_o <= 1'b1;
			repeat (4) @(posedge clk_sys_i);
			ser_clk_o <= 1'b0;
		end
		repeat (4) @(posedge clk_sys_i);
		ser_enable_n_o <= 1'b1;
		// Released data line must not keep its last bit
		ser_data_o <= ~ser_data_o;
	endtask
endmodule

// File: tb/gain_current_serial_load_tb.sv
// Self-checking bench for the serial gain/current load port.
// Assumes the host model drives the three serial pins.
`timescale 1ns/1ps
module gain_current_serial_load_tb;
	import gain_load_pkg::*;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic tx_on_i = 1'b0;
	logic sd, sc, se_n, amp_on, stage_on;
	logic [gain_bits-1:0] gain;
	logic [current_bits-1:0] cur;
	logic [word_bits-1:0] word;
	int n_errors = 0;
	int check_count = 0;
	gain_host_model u_host (.clk_sys_i(clk_sys_i), .ser_data_o(sd), .ser_clk_o(sc),
		.ser_enable_n_o(se_n));
	gain_current_serial_load u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ser_data_i(sd),
		.ser_clk_i(sc), .ser_enable_n_i(se_n), .tx_on_i(tx_on_i), .amp_on_o(amp_on),
		.input_stage_on_o(stage_on), .gain_code_o(gain), .current_code_o(cur),
		.control_word_o(word));
	initial forever #20 clk_sys_i = ~clk_sys_i;
	function automatic logic [9:0] mk(input logic [4:0] g, input logic [2:0] c);
		return {c, g, 2'b01};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("errors=%0d checks=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic set_tx(input logic v);
		tx_on_i <= v;
		repeat (6) @(posedge clk_sys_i);
	endtask
	task automatic expect_set(input logic [9:0] w);
		check(gain, w[6:2]);
		check(cur, w[9:7]);
		check(amp_on, w[9:7] != current_off);
		check(stage_on, w[9:7] != current_off);
	endtask
	initial begin
		logic [9:0] w;
		logic [9:0] prev;
		void'($urandom(32'h7b174819));
		repeat (5) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		check(word, word_reset);
		for (int i = 0; i < 8; i++) begin
			w = (i == 0) ? mk(5'h1f, 3'h7) : (i == 1) ? mk(5'h0, 3'h0) : mk(5'($urandom), 3'($urandom));
			u_host.send(w, 10);
			repeat (6) @(posedge clk_sys_i);
			check(word, w);
			set_tx(1'b0);
			set_tx(1'b1);
			expect_set(w);
		end
		// New word while on waits for an off/on cycle
		prev = w;
		w = mk(~prev[6:2], (prev[9:7] == 3'h7) ? 3'h3 : 3'h7);
		u_host.send({3'h5, w}, 13);
		repeat (6) @(posedge clk_sys_i);
		check(word, w);
		expect_set(prev);
		set_tx(1'b0);
		check(amp_on, 1'b0);
		check(stage_on, 1'b0);
		check(gain, prev[6:2]);
		set_tx(1'b1);
		expect_set(w);
		reset_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		check(word, word_reset);
		check(amp_on, 1'b0);
		stop_test;
	end
	initial begin
		repeat (40000) @(posedge clk_sys_i);
		n_errors++;
		stop_test;
	end
endmodule
